// [design/startup_reset_sequencer.sv]
// Purpose: Start-up and reset sequencing with strap capture and PLL wait
// Assumes: clk_i is the input clock; straps and pins are asynchronous
// Notes:   Wishbone classic slave answers one cycle after a request
`timescale 1ns/1ns
module startup_reset_sequencer
	import seq_pkg::*;
(
	// Clock and reset
	input  wire logic                     clk_i,
	input  wire logic                     rst_i,
	// Wishbone slave
	input  wire logic                     wb_cyc_i,
	input  wire logic                     wb_stb_i,
	input  wire logic                     wb_we_i,
	input  wire logic [seq_pkg::ADR_W-1:0] wb_adr_i,
	input  wire logic [3:0]               wb_sel_i,
	input  wire logic [seq_pkg::DAT_W-1:0] wb_dat_i,
	output logic      [seq_pkg::DAT_W-1:0] wb_dat_o,
	output logic                          wb_ack_o,
	// Board pins
	input  wire logic                     ext_reset_n_i,
	input  wire logic [1:0]               boot_cfg_i,
	input  wire logic [1:0]               clk_cfg_i,
	// Shared reset pin
	input  wire logic                     reset_pin_i,
	output logic                          reset_pin_o,
	output logic                          reset_pin_oe_n_o,
	// Core side
	output logic                          core_reset_o,
	output logic                          core_start_o,
	output logic      [31:0]              start_addr_o,
	output logic      [1:0]               boot_mode_o,
	output logic      [seq_pkg::MULT_W-1:0] pll_mult_o,
	output logic      [seq_pkg::DIV_W-1:0] pll_div_o,
	output logic                          pll_locked_o
);
	import seq_pkg::*;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	////////////////////////////////////////////////////////////////////////
	// Declarations
	logic                  ext_n_s;      // Synchronised reset pin level
	logic [1:0]            boot_s;       // Synchronised boot straps
	logic [1:0]            ratio_s;      // Synchronised ratio straps
	logic                  pin_s;        // Synchronised shared pin level
	seq_state_type         state_q;      // Sequencer state
	seq_state_type         state_d;      // Next state
	logic [LOCK_CNT_W-1:0] lock_cnt_q;   // Lock wait counter
	logic [1:0]            ratio_q;      // Latched ratio straps
	logic                  rr_en_q;      // Shared pin used as input
	logic                  req;          // Bus request waiting
	logic                  wr_pm;        // Write to power control
	logic                  wr_rr;        // Write to running reset control
	logic                  sw_ok;        // Core running or in running reset
	logic [DAT_W-1:0]      rd_data;      // Read mux

	////////////////////////////////////////////////////////////////////////
	// Synchronisers for asynchronous inputs
	sync2 #(.W(1), .INIT(1'b0)) u_sync_rst (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.d_i   (ext_reset_n_i),
		.q_o   (ext_n_s)
	);

	sync2 #(.W(4), .INIT(4'h0)) u_sync_straps (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.d_i   ({boot_cfg_i, clk_cfg_i}),
		.q_o   ({boot_s, ratio_s})
	);

	sync2 #(.W(1), .INIT(1'b1)) u_sync_pin (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.d_i   (reset_pin_i),
		.q_o   (pin_s)
	);

	////////////////////////////////////////////////////////////////////////
	// Sequencer next state
	always_comb begin
		state_d = state_q;
		case (state_q)
			// Held while the reset pin is low
			S_HOLD: begin
				if (ext_n_s)
					state_d = S_LOCK;
			end
			// Wait a fixed count for the PLL to lock
			S_LOCK: begin
				if (!ext_n_s)
					state_d = S_HOLD;
				else if (lock_cnt_q == LOCK_CNT_W'(LOCK_CYCLES - 1))
					state_d = S_RUN;
			end
			// Core executing
			S_RUN: begin
				if (!ext_n_s)
					state_d = S_HOLD;
				else if (rr_en_q && !pin_s)
					state_d = S_RUNRST;
			end
			// Running reset driven in on the shared pin
			S_RUNRST: begin
				if (!ext_n_s)
					state_d = S_HOLD;
				else if (pin_s || !rr_en_q)
					state_d = S_RUN;
			end
			default: state_d = S_HOLD;
		endcase
	end

	// State register
	always_ff @(posedge clk_i) begin
		if (rst_i)
			state_q <= S_HOLD;
		else
			state_q <= state_d;
	end

	////////////////////////////////////////////////////////////////////////
	// Lock wait counter, runs only in the lock state
	always_ff @(posedge clk_i) begin
		if (rst_i || state_q != S_LOCK)
			lock_cnt_q <= '0;
		else
			lock_cnt_q <= lock_cnt_q + LOCK_CNT_W'(1);
	end

	////////////////////////////////////////////////////////////////////////
	// Core side outputs, registered; reset, start and lock from the next state, start address fixed at the vector
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			core_reset_o <= 1'b1;
			core_start_o <= 1'b0;
			start_addr_o <= RESET_VECTOR;
			pll_locked_o <= 1'b0;
		end else begin
			// Core held unless running
			core_reset_o <= (state_d != S_RUN);
			// One pulse on each start from the vector
			core_start_o <= (state_d == S_RUN) && (state_q != S_RUN);
			start_addr_o <= RESET_VECTOR;
			// Lock shown from the end of the wait through running reset, cleared again in hold and lock wait
			pll_locked_o <= (state_d == S_RUN) || (state_d == S_RUNRST);
		end
	end

	// Reset output level: low through reset and lock wait
	always_ff @(posedge clk_i) begin
		if (rst_i)
			reset_pin_o <= 1'b0;
		else
			reset_pin_o <= (state_d == S_RUN) || (state_d == S_RUNRST);
	end

	////////////////////////////////////////////////////////////////////////
	// Strap capture while the reset pin holds the part
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			boot_mode_o <= 2'h0;
			ratio_q     <= 2'h0;
		end else if (state_q == S_HOLD) begin
			boot_mode_o <= boot_s;
			ratio_q     <= ratio_s;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Bus decode
	assign req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign sw_ok = (state_q == S_RUN) || (state_q == S_RUNRST);
	assign wr_pm = req && wb_we_i && wb_sel_i[0] && (wb_adr_i == PWR_CTL_OFS);
	assign wr_rr = req && wb_we_i && wb_sel_i[0] && (wb_adr_i == RRCTL_OFS);

	////////////////////////////////////////////////////////////////////////
	// Power control: straps give start-up ratio, software may rewrite
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pll_mult_o <= ratio_mult(2'h0);
			pll_div_o  <= DIV_RESET;
		end else if (state_q == S_HOLD) begin
			// Start-up ratio from the straps
			pll_mult_o <= ratio_mult(ratio_s);
			pll_div_o  <= DIV_RESET;
		end else if (wr_pm && sw_ok) begin
			// Software frequency change after reset
			pll_mult_o <= wb_dat_i[MULT_LSB +: MULT_W];
			pll_div_o  <= wb_dat_i[DIV_LSB +: DIV_W];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Running reset control, cleared by rst_i and in the hold state, kept through running reset
	always_ff @(posedge clk_i) begin
		if (rst_i || state_q == S_HOLD)
			rr_en_q <= 1'b0;
		else if (wr_rr)
			rr_en_q <= wb_dat_i[RR_EN_BIT];
	end

	// Pin direction: driven unless the input function is chosen
	assign reset_pin_oe_n_o = rr_en_q;

	////////////////////////////////////////////////////////////////////////
	// Read mux, unmapped offsets read zero
	always_comb begin
		rd_data = '0;
		case (wb_adr_i)
			PWR_CTL_OFS: begin
				rd_data[MULT_LSB +: MULT_W] = pll_mult_o;
				rd_data[DIV_LSB +: DIV_W]   = pll_div_o;
			end
			RRCTL_OFS: rd_data[RR_EN_BIT] = rr_en_q;
			STATUS_OFS: begin
				rd_data[ST_RUN_BIT]        = (state_q == S_RUN);
				rd_data[ST_LOCK_BIT]       = (state_q == S_LOCK);
				rd_data[ST_BOOT_LSB +: 2]  = boot_mode_o;
				rd_data[ST_RATIO_LSB +: 2] = ratio_q;
				rd_data[ST_PIN_BIT]        = pin_s;
			end
			default: rd_data = '0;
		endcase
	end

	// Acknowledge one cycle after each request, dropped the next
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			wb_ack_o <= req;
			wb_dat_o <= req ? rd_data : '0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	sequence lock_end_s;
		state_q == S_LOCK && state_d == S_RUN;
	endsequence

	sequence start_s;
		core_start_o && !core_reset_o ##1 !core_start_o;
	endsequence

	sequence pin_low_s;
		state_q == S_RUN && rr_en_q && !pin_s && ext_n_s;
	endsequence

	lock_length_a: assert property (
		lock_end_s |-> lock_cnt_q == LOCK_CNT_W'(LOCK_CYCLES - 1) && ext_n_s)
		else $error("core started before lock count ended");

	start_pulse_a: assert property (
		lock_end_s |=> start_s)
		else $error("start pulse missing after lock wait");

	boot_latch_a: assert property (
		state_q == S_HOLD |=> boot_mode_o == $past(boot_s))
		else $error("boot mode not taken from straps");

	ratio_load_a: assert property (
		state_q == S_HOLD |=> pll_mult_o == ratio_mult($past(ratio_s)) && pll_div_o == DIV_RESET)
		else $error("start-up ratio not taken from straps");

	pwr_write_a: assert property (
		wr_pm && sw_ok && state_d != S_HOLD |=> pll_mult_o == $past(wb_dat_i[MULT_LSB +: MULT_W])
			&& pll_div_o == $past(wb_dat_i[DIV_LSB +: DIV_W]))
		else $error("power control write lost");

	pin_default_a: assert property (
		state_q == S_HOLD |=> !reset_pin_oe_n_o [*2])
		else $error("shared pin not reset output by default");

	reset_out_a: assert property (
		state_q == S_LOCK && state_d == S_LOCK |=> !reset_pin_o && core_reset_o)
		else $error("reset output released during lock wait");

	bus_ack_a: assert property (
		req |=> wb_ack_o ##1 !wb_ack_o)
		else $error("bus answer not a single cycle");

	run_reset_in_a: assert property (
		pin_low_s |=> core_reset_o && state_q == S_RUNRST)
		else $error("running reset input not taken");

	pin_ignored_a: assert property (
		state_q == S_RUN && !rr_en_q && ext_n_s |=> !core_reset_o)
		else $error("shared pin taken as input while driven");

	hold_out_a: assert property (
		state_q == S_HOLD && state_d == S_HOLD |=> !reset_pin_o && core_reset_o)
		else $error("reset output released during reset");

	lock_flag_a: assert property (
		state_q == S_LOCK && state_d != S_RUN |=> !pll_locked_o)
		else $error("lock shown before wait ended");

	pwr_refuse_a: assert property (
		wr_pm && state_q == S_LOCK |=> $stable(pll_mult_o) && $stable(pll_div_o))
		else $error("power control changed before core start");

endmodule // startup_reset_sequencer

// [design/seq_pkg.sv]
// Purpose: Shared constants for the start-up and reset sequencer
// Assumes: One 250 MHz input clock; classic Wishbone register slave
// Notes:   Offsets are byte addresses of aligned 32-bit words
package seq_pkg;

	////////////////////////////////////////////////////////////////////////
	// Bus geometry
	localparam int          ADR_W            = 8;              // Byte address width
	localparam int          DAT_W            = 32;             // Data width

	////////////////////////////////////////////////////////////////////////
	// Register offsets
	localparam logic [7:0]  PWR_CTL_OFS      = 8'h00;          // Power management control
	localparam logic [7:0]  RRCTL_OFS        = 8'h04;          // Running reset control
	localparam logic [7:0]  STATUS_OFS       = 8'h08;          // Sequencer status

	////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int          MULT_LSB         = 0;              // PLL multiplier field
	localparam int          MULT_W           = 6;
	localparam int          DIV_LSB          = 6;              // PLL divider field
	localparam int          DIV_W            = 2;
	localparam int          RR_EN_BIT        = 0;              // Running reset input enable
	localparam int          ST_RUN_BIT       = 0;              // Core running
	localparam int          ST_LOCK_BIT      = 1;              // Lock wait in progress
	localparam int          ST_BOOT_LSB      = 2;              // Latched boot mode
	localparam int          ST_RATIO_LSB     = 4;              // Latched ratio straps
	localparam int          ST_PIN_BIT       = 6;              // Synchronised pin level

	////////////////////////////////////////////////////////////////////////
	// Reset values and strap ratio table
	localparam logic [1:0]  DIV_RESET        = 2'h0;           // Divider after reset
	localparam logic [5:0]  MULT_RATIO0      = 6'h06;          // Ratio strap 0
	localparam logic [5:0]  MULT_RATIO1      = 6'h20;          // Ratio strap 1
	localparam logic [5:0]  MULT_RATIO2      = 6'h10;          // Ratio strap 2
	localparam logic [5:0]  MULT_RATIO3      = 6'h06;          // Ratio strap 3
	localparam logic [31:0] RESET_VECTOR     = 32'h0009_0000;  // Arbitrary start address

	////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int          LOCK_CYCLES      = 4096;           // Input-clock cycles of lock wait
	localparam int          LOCK_CNT_W       = 13;             // Lock counter width

	////////////////////////////////////////////////////////////////////////
	// Sequencer states
	typedef enum logic [1:0] {
		S_HOLD,
		S_LOCK,
		S_RUN,
		S_RUNRST
	} seq_state_type;

	// Start-up multiplier for a ratio strap setting
	function automatic logic [5:0] ratio_mult(input logic [1:0] cfg);
		case (cfg)
			2'h0:    ratio_mult = MULT_RATIO0;
			2'h1:    ratio_mult = MULT_RATIO1;
			2'h2:    ratio_mult = MULT_RATIO2;
			default: ratio_mult = MULT_RATIO3;
		endcase
	endfunction

endpackage

// [design/sync2.sv]
// Purpose: Two-flop synchroniser for pins from outside the clock domain
// Assumes: Bits are independent levels
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ns
module sync2 #(
	parameter int         W    = 1,     // Bits carried
	parameter logic [W-1:0] INIT = '0   // Value under reset
) (
	// Clock and reset
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	// Data
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);

	logic [W-1:0] meta_q;  // First stage

	// Two flops in a row
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_q <= INIT;
			q_o    <= INIT;
		end else begin
			meta_q <= d_i;
			q_o    <= meta_q;
		end
	end

endmodule // sync2

// [dv/board_model.sv]
// Purpose: Board supervisor and strap source for the sequencer
// Assumes: Shared reset pin has a pull-up
// Notes:   Bench commands the reset, straps and pin pull-down
`timescale 1ns/1ns
module board_model (
	// Bench commands
	input  wire logic       hold_rst_i,
	input  wire logic [1:0] boot_i,
	input  wire logic [1:0] ratio_i,
	input  wire logic       pull_low_i,
	// Device pin drive
	input  wire logic       dev_pin_i,
	input  wire logic       dev_oe_n_i,
	// Board pins
	output logic            ext_reset_n_o,
	output logic [1:0]      boot_cfg_o,
	output logic [1:0]      clk_cfg_o,
	output logic            pin_level_o
);
	// Test clock and test reset held low
	logic test_clk_lvl;
	logic test_rst_n_lvl;
	assign test_clk_lvl   = 1'b0;
	assign test_rst_n_lvl = 1'b0;
	// Reset held low from power-up while commanded
	assign ext_reset_n_o = ~hold_rst_i;
	// Straps settle before reset is asserted, then stay put
	assign boot_cfg_o = boot_i;
	assign clk_cfg_o  = ratio_i;
	// Device drive wins, else pull-up unless pulled low
	assign pin_level_o = (dev_oe_n_i == 1'b0) ? dev_pin_i : ~pull_low_i;
endmodule // board_model

// [dv/testbench.sv]
// Purpose: Self-checking bench for the start-up sequencer
// Assumes: Lock wait of 4096 cycles runs in full
// Notes:   Bus master is classic Wishbone
`timescale 1ns/1ns
module testbench;
	import seq_pkg::*;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [3:0]  sel = 4'h0;
	logic [31:0] wdat = 32'h0000_0000;
	logic [31:0] rdat;
	logic        ack;
	logic        hold_rst = 1'b1;
	logic        pull_low = 1'b0;
	logic [1:0]  boot = 2'h2;
	logic [1:0]  ratio = 2'h1;
	logic        ext_n, pin_lvl, pin_out, oe_n, core_rst, core_go, locked;
	logic [1:0]  bcfg, ccfg, bmode, div;
	logic [31:0] vec;
	logic [5:0]  mult;
	int          bad_count = 0;
	int          total_checks = 0;
	////////////////////////////////////////////////////////////////////////
	// Steady free-running clock
	initial begin
		forever #2 clk_i = ~clk_i;
	end
	board_model board_u (.hold_rst_i(hold_rst), .boot_i(boot), .ratio_i(ratio), .pull_low_i(pull_low),
		.dev_pin_i(pin_out), .dev_oe_n_i(oe_n), .ext_reset_n_o(ext_n), .boot_cfg_o(bcfg),
		.clk_cfg_o(ccfg), .pin_level_o(pin_lvl));
	startup_reset_sequencer dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.ext_reset_n_i(ext_n), .boot_cfg_i(bcfg), .clk_cfg_i(ccfg), .reset_pin_i(pin_lvl),
		.reset_pin_o(pin_out), .reset_pin_oe_n_o(oe_n), .core_reset_o(core_rst), .core_start_o(core_go),
		.start_addr_o(vec), .boot_mode_o(bmode), .pll_mult_o(mult), .pll_div_o(div), .pll_locked_o(locked));
	////////////////////////////////////////////////////////////////////////
	// Compare and count
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// One classic bus cycle, held until ack
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= 4'hf;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 50);
		q = rdat;
		if (n >= 50) bad_count++;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask
	////////////////////////////////////////////////////////////////////////
	// Reset, new straps, lock wait with a refused write
	task automatic startup(input logic [1:0] b, input logic [1:0] r, input logic [5:0] m);
		int n;
		logic held;
		logic [31:0] q;
		@(posedge clk_i);
		boot <= b;
		ratio <= r;
		repeat (4) @(posedge clk_i);
		hold_rst <= 1'b1;
		repeat (4) @(posedge clk_i);
		hold_rst <= 1'b0;
		held = 1'b1;
		n = 0;
		fork
			begin
				repeat (100) @(posedge clk_i);
				wb(1'b1, PWR_CTL_OFS, 32'h0000_00bf, q);
			end
			do begin
				@(posedge clk_i);
				#1;
				n++;
				if (core_go !== 1'b1)
					held &= (core_rst === 1'b1 && pin_out === 1'b0 && oe_n === 1'b0 && locked === 1'b0);
			end while (core_go !== 1'b1 && n < 5000);
		join
		check("start delay ok", 32'(n >= 4098 && n <= 4101), 32'h0000_0001);
		check("held in wait", 32'(held), 32'h0000_0001);
		check("locked", 32'(locked), 32'h0000_0001);
		check("core reset", 32'(core_rst), 32'h0000_0000);
		check("reset pin", 32'(pin_out), 32'h0000_0001);
		check("vector", vec, RESET_VECTOR);
		check("boot mode", 32'(bmode), 32'(b));
		check("mult", 32'(mult), 32'(m));
		check("div", 32'(div), 32'h0000_0000);
		@(posedge clk_i);
		#1;
		check("start pulse end", 32'(core_go), 32'h0000_0000);
		$display("test startup done");
	endtask
	// Power control after start, status, unmapped read
	task automatic regs();
		logic [31:0] q;
		wb(1'b1, PWR_CTL_OFS, 32'h0000_0095, q);
		#1;
		check("mult new", 32'(mult), 32'h0000_0015);
		check("div new", 32'(div), 32'h0000_0002);
		wb(1'b0, PWR_CTL_OFS, 32'h0000_0000, q);
		check("power read", q, 32'h0000_0095);
		wb(1'b0, STATUS_OFS, 32'h0000_0000, q);
		check("status", q, 32'h0000_0059);
		wb(1'b0, 8'h0c, 32'h0000_0000, q);
		check("unmapped", q, 32'h0000_0000);
		$display("test regs done");
	endtask
	// Shared pin as output, then as running reset input
	task automatic runrst();
		logic [31:0] q;
		int pulses;
		@(posedge clk_i);
		pull_low <= 1'b1;
		repeat (8) @(posedge clk_i);
		#1;
		check("pin ignored", 32'(core_rst), 32'h0000_0000);
		check("pin driven", 32'(oe_n), 32'h0000_0000);
		@(posedge clk_i);
		pull_low <= 1'b0;
		wb(1'b1, RRCTL_OFS, 32'h0000_0001, q);
		repeat (3) @(posedge clk_i);
		#1;
		check("pin released", 32'(oe_n), 32'h0000_0001);
		@(posedge clk_i);
		pull_low <= 1'b1;
		repeat (6) @(posedge clk_i);
		#1;
		check("run reset", 32'(core_rst), 32'h0000_0001);
		@(posedge clk_i);
		pull_low <= 1'b0;
		pulses = 0;
		repeat (6) begin
			@(posedge clk_i);
			#1;
			pulses += int'(core_go === 1'b1);
		end
		check("restart pulse", 32'(pulses), 32'h0000_0001);
		check("run again", 32'(core_rst), 32'h0000_0000);
		check("no relock", 32'(locked), 32'h0000_0001);
		$display("test running reset done");
	endtask
	////////////////////////////////////////////////////////////////////////
	// Verdict and end of run
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		startup(2'h2, 2'h1, 6'h20);
		regs();
		runrst();
		startup(2'h1, 2'h2, 6'h10);
		give_verdict();
	end
	// Watchdog against a hang
	initial begin
		repeat (20000) @(posedge clk_i);
		bad_count++;
		give_verdict();
	end
endmodule // testbench
